// ==== rtl/light_sensor_consts.vh ====
// Constants for the light sensor command and readout block.
// Included by the command and readout design file; holds definitions only.
`ifndef LIGHT_SENSOR_CONSTS_VH
`define LIGHT_SENSOR_CONSTS_VH

// Fixed upper four bits of the 7-bit bus address
`define ADDR_UPPER_BITS 4'h8

// Command codes
`define CMD_POWER_DOWN 8'h8C
`define CMD_ADC_RESET 8'h0C
`define CMD_INT_PRIMARY 8'h00
`define CMD_INT_DARK 8'h04
`define CMD_INT_DIFF 8'h08
`define CMD_EXT_PRIMARY 8'h30
`define CMD_EXT_DARK 8'h34
`define CMD_EXT_DIFF 8'h38
`define CMD_TEST_BIT 7

// Command field that selects the photodiode source
`define CMD_SRC_MSB 3
`define CMD_SRC_LSB 2
`define SRC_PRIMARY 2'h0
`define SRC_DARK 2'h1
`define SRC_DIFF 2'h2

// Reset value of the command register
`define CMD_RESET_VALUE 8'h8C

// Oscillator cycles in one internally timed integration, less one
`define INT_LAST_CYCLE 16'h7FFF

// Readout byte indices and how many bytes each timing class offers
`define IDX_READING_LOW 2'h0
`define IDX_READING_HIGH 2'h1
`define IDX_COUNT_LOW 2'h2
`define IDX_COUNT_HIGH 2'h3
`define BYTES_INTERNAL 3'h2
`define BYTES_EXTERNAL 3'h4

`endif

// ==== rtl/pin_sync.v ====
// Two-stage synchroniser with a third stage for edge detection.
// Assumes asynchronous inputs; outputs are on the i_sys_clk domain.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter WIDTH = 1
) (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_level,
   output wire [WIDTH-1:0] o_rise,
   output wire [WIDTH-1:0] o_fall
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;
   reg [WIDTH-1:0] last_reg;

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= {WIDTH{1'b1}};
         sync_reg <= {WIDTH{1'b1}};
         last_reg <= {WIDTH{1'b1}};
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign o_level = sync_reg;
   assign o_rise = sync_reg & ~last_reg;
   assign o_fall = ~sync_reg & last_reg;

endmodule

`default_nettype wire

// ==== rtl/light_sensor_command_readout.v ====
// Bus slave, command decoder and conversion sequencer of the light sensor.
// Assumes bus lines, oscillator and photocurrent pulse trains are asynchronous
// to i_sys_clk and each high or low phase lasts at least three system clocks.
// How it works
// - Answer address 1000 plus three select pins
// - One 8-bit command register holds operation
// - Each write data byte overwrites command
// - Reads return reading low, high, count low, high
// - Internal modes release bus after two bytes
// - Readout registers update only on completion
// - Early reads return the previous reading
// - Address-only write repeats the held command
// - 8C powers converter down, others re-enable
// - 0C clears conversion and cycle counts
// - 00/04/08 self-timed primary, dark, difference
// - 30/34/38 externally timed, each restarts integration
// - Single diode result is unsigned 16-bit
// - Difference integrates dark then primary, signed
// - Internal integration lasts 2^15 oscillator cycles
// - Bytes three and four hold cycle count
// - Oscillator counter latched at integration end
// - Top-bit commands other than 8C are echoed back on read
`timescale 1ns/1ps
`default_nettype none
`include "light_sensor_consts.vh"

module light_sensor_command_readout (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_scl,
   input wire i_sda,
   output wire o_sda,
   output wire o_sda_oe_n,
   input wire i_addr_select_bit0,
   input wire i_addr_select_bit1,
   input wire i_addr_select_bit2,
   input wire i_osc_clk,
   input wire i_primary_photocurrent,
   input wire i_dark_photocurrent,
   output wire o_adc_enabled,
   output wire o_conv_busy
);

   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_ADDR_ACK = 7'h04;
   localparam [6:0] S_WRITE = 7'h08;
   localparam [6:0] S_WRITE_ACK = 7'h10;
   localparam [6:0] S_READ = 7'h20;
   localparam [6:0] S_READ_ACK = 7'h40;

   wire [7:0] sync_in;
   wire [7:0] sync_level;
   wire [7:0] sync_rise;
   wire [7:0] sync_fall;

   assign sync_in = {i_dark_photocurrent, i_primary_photocurrent, i_osc_clk,
                     i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0,
                     i_sda, i_scl};

   pin_sync #(
      .WIDTH(8)
   ) u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async(sync_in),
      .o_level(sync_level),
      .o_rise(sync_rise),
      .o_fall(sync_fall)
   );

   wire scl_level = sync_level[0];
   wire sda_level = sync_level[1];
   wire scl_rise = sync_rise[0];
   wire scl_fall = sync_fall[0];
   wire [2:0] addr_pins = sync_level[4:2];
   wire osc_rise = sync_rise[5];
   wire primary_rise = sync_rise[6];
   wire dark_rise = sync_rise[7];

   // Start and stop conditions: data moves while the clock is high
   wire start_det = scl_level & sync_fall[1];
   wire stop_det = scl_level & sync_rise[1];

   reg [6:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg [7:0] tx_reg;
   reg [1:0] byte_idx_reg;
   reg rw_reg;
   reg master_ack_reg;
   reg sda_drive_reg;
   reg wr_seen_reg;
   reg exec_reg;
   reg [7:0] command_reg;

   reg adc_en_reg;
   reg run_reg;
   reg run_ext_reg;
   reg [1:0] src_reg;
   reg phase_dark_reg;
   reg [15:0] cyc_cnt_reg;
   reg [15:0] pulse_cnt_reg;
   reg [15:0] dark_cnt_reg;
   reg [15:0] reading_reg;
   reg [15:0] count_reg;

   // Command decode; power-down is checked ahead of the test class
   wire is_pdn = (command_reg == `CMD_POWER_DOWN);
   wire is_test = command_reg[`CMD_TEST_BIT] & ~is_pdn;
   wire is_int = (command_reg == `CMD_INT_PRIMARY) | (command_reg == `CMD_INT_DARK) |
                 (command_reg == `CMD_INT_DIFF);
   wire is_ext = (command_reg == `CMD_EXT_PRIMARY) | (command_reg == `CMD_EXT_DARK) |
                 (command_reg == `CMD_EXT_DIFF);
   wire [1:0] cmd_src = command_reg[`CMD_SRC_MSB:`CMD_SRC_LSB];

   wire src_diff = (src_reg == `SRC_DIFF);
   wire count_primary = (src_reg == `SRC_PRIMARY) | (src_diff & ~phase_dark_reg);
   wire count_dark = (src_reg == `SRC_DARK) | (src_diff & phase_dark_reg);
   wire pulse_hit = (count_primary & primary_rise) | (count_dark & dark_rise);
   wire [15:0] pulse_next = (pulse_cnt_reg == 16'hFFFF) ? pulse_cnt_reg :
                            pulse_cnt_reg + 16'h0001;
   // Difference result wraps as two's complement
   wire [15:0] result = src_diff ? (pulse_cnt_reg - dark_cnt_reg) : pulse_cnt_reg;
   wire int_end = run_reg & ~run_ext_reg & osc_rise &
                  (cyc_cnt_reg == `INT_LAST_CYCLE);
   wire ext_fin = exec_reg & is_ext & run_reg & run_ext_reg;
   wire diff_dark_now = src_diff & phase_dark_reg;
   // Count bytes only while an externally timed mode runs
   wire [2:0] bytes_allowed = (run_reg & run_ext_reg) ? `BYTES_EXTERNAL : `BYTES_INTERNAL;
   wire [2:0] next_idx = {1'b0, byte_idx_reg} + 3'h1;
   wire addr_match = (shift_reg[7:1] == {`ADDR_UPPER_BITS, addr_pins});

   function [7:0] rd_byte;
      input [1:0] idx;
      input test;
      input [7:0] cmd;
      input [15:0] rd;
      input [15:0] cnt;
      begin
         if (test) begin
            rd_byte = cmd;
         end else begin
            case (idx)
               `IDX_READING_LOW: rd_byte = rd[7:0];
               `IDX_READING_HIGH: rd_byte = rd[15:8];
               `IDX_COUNT_LOW: rd_byte = cnt[7:0];
               default: rd_byte = cnt[15:8];
            endcase
         end
      end
   endfunction

   wire [7:0] first_byte = rd_byte(`IDX_READING_LOW, is_test, command_reg,
                                   reading_reg, count_reg);
   wire [7:0] next_byte = rd_byte(next_idx[1:0], is_test, command_reg,
                                  reading_reg, count_reg);

   // Bus slave
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= S_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         byte_idx_reg <= 2'h0;
         rw_reg <= 1'b0;
         master_ack_reg <= 1'b0;
         sda_drive_reg <= 1'b0;
         wr_seen_reg <= 1'b0;
         exec_reg <= 1'b0;
         command_reg <= `CMD_RESET_VALUE;
      end else begin
         exec_reg <= 1'b0;
         if (start_det | stop_det) begin
            // A write addressed here executes at its end, data or not
            exec_reg <= wr_seen_reg;
            wr_seen_reg <= 1'b0;
            sda_drive_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= start_det ? S_ADDR : S_IDLE;
         end else begin
            case (state_reg)
               S_IDLE: begin
                  sda_drive_reg <= 1'b0;
               end
               S_ADDR: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_level};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     if (addr_match) begin
                        sda_drive_reg <= 1'b1;
                        rw_reg <= shift_reg[0];
                        state_reg <= S_ADDR_ACK;
                     end else begin
                        state_reg <= S_IDLE;
                     end
                  end
               end
               S_ADDR_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (rw_reg) begin
                        // No sub-address: a read always starts at byte 0
                        tx_reg <= first_byte;
                        byte_idx_reg <= `IDX_READING_LOW;
                        sda_drive_reg <= ~first_byte[7];
                        state_reg <= S_READ;
                     end else begin
                        sda_drive_reg <= 1'b0;
                        wr_seen_reg <= 1'b1;
                        state_reg <= S_WRITE;
                     end
                  end
               end
               S_WRITE: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_level};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     command_reg <= shift_reg;
                     sda_drive_reg <= 1'b1;
                     state_reg <= S_WRITE_ACK;
                  end
               end
               S_WRITE_ACK: begin
                  if (scl_fall) begin
                     sda_drive_reg <= 1'b0;
                     bit_cnt_reg <= 4'h0;
                     state_reg <= S_WRITE;
                  end
               end
               S_READ: begin
                  if (scl_rise) begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_reg == 4'h8) begin
                        sda_drive_reg <= 1'b0;
                        state_reg <= S_READ_ACK;
                     end else begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_drive_reg <= ~tx_reg[6];
                     end
                  end
               end
               S_READ_ACK: begin
                  if (scl_rise) begin
                     master_ack_reg <= ~sda_level;
                  end else if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (master_ack_reg && next_idx < bytes_allowed) begin
                        tx_reg <= next_byte;
                        byte_idx_reg <= next_idx[1:0];
                        sda_drive_reg <= ~next_byte[7];
                        state_reg <= S_READ;
                     end else begin
                        sda_drive_reg <= 1'b0;
                        state_reg <= S_IDLE;
                     end
                  end
               end
               default: begin
                  sda_drive_reg <= 1'b0;
                  state_reg <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Conversion sequencer; readout registers change only at an integration end
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         adc_en_reg <= 1'b0;
         run_reg <= 1'b0;
         run_ext_reg <= 1'b0;
         src_reg <= `SRC_PRIMARY;
         phase_dark_reg <= 1'b0;
         cyc_cnt_reg <= 16'h0000;
         pulse_cnt_reg <= 16'h0000;
         dark_cnt_reg <= 16'h0000;
         reading_reg <= 16'h0000;
         count_reg <= 16'h0000;
      end else if (exec_reg) begin
         pulse_cnt_reg <= 16'h0000;
         cyc_cnt_reg <= 16'h0000;
         if (ext_fin) begin
            if (diff_dark_now) begin
               dark_cnt_reg <= pulse_cnt_reg;
            end else begin
               reading_reg <= result;
               count_reg <= cyc_cnt_reg;
            end
         end
         if (is_pdn) begin
            adc_en_reg <= 1'b0;
            run_reg <= 1'b0;
         end else begin
            adc_en_reg <= 1'b1;
            if (is_int | is_ext) begin
               run_reg <= 1'b1;
               run_ext_reg <= is_ext;
               src_reg <= cmd_src;
               // Difference runs dark first, then primary
               phase_dark_reg <= (cmd_src == `SRC_DIFF) & ~(ext_fin & diff_dark_now);
            end else begin
               run_reg <= 1'b0;
            end
         end
      end else if (int_end) begin
         pulse_cnt_reg <= 16'h0000;
         cyc_cnt_reg <= 16'h0000;
         if (diff_dark_now) begin
            dark_cnt_reg <= pulse_cnt_reg;
            phase_dark_reg <= 1'b0;
         end else begin
            reading_reg <= result;
            count_reg <= cyc_cnt_reg + 16'h0001;
            phase_dark_reg <= src_diff;
         end
      end else if (run_reg) begin
         if (osc_rise) begin
            cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
         end
         if (pulse_hit) begin
            pulse_cnt_reg <= pulse_next;
         end
      end
   end

   assign o_sda = 1'b0;
   assign o_sda_oe_n = ~sda_drive_reg;
   assign o_adc_enabled = adc_en_reg;
   assign o_conv_busy = run_reg;

endmodule

`default_nettype wire

// ==== testbench/light_sensor_chk.sv ====
// Checker bound to the light sensor readout block.
// Assumes i_sda carries the resolved data line level.
`timescale 1ns/1ps
`default_nettype none

module light_sensor_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe_n,
   input wire logic o_adc_enabled,
   input wire logic o_conv_busy
);
   logic scl_q;
   logic sda_q;
   logic in_frame;
   logic [6:0] stop_age;
   wire stop_seen = scl_q & i_scl & ~sda_q & i_sda;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Start and stop seen on the pins
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         in_frame <= 1'b0;
         stop_age <= 7'h7F;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
         if (scl_q && i_scl && sda_q && !i_sda) begin
            in_frame <= 1'b1;
         end else if (stop_seen) begin
            in_frame <= 1'b0;
         end
         stop_age <= stop_seen ? 7'h00 : stop_age + {6'h00, stop_age != 7'h7F};
      end
   end
   AST_RESET_STATE: assert property (
      $rose(i_rst_n) |-> o_sda_oe_n && !o_adc_enabled && !o_conv_busy)
      else $error("outputs not idle after reset");
   AST_PULL_LOW_ONLY: assert property (
      !o_sda_oe_n |-> o_sda == 1'b0)
      else $error("data pin driven high");
   AST_DRIVE_IN_FRAME: assert property (
      !o_sda_oe_n |-> in_frame)
      else $error("data pin driven outside a transfer");
   AST_CHANGE_SCL_LOW: assert property (
      $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl))
      else $error("data drive changed while clock high");
   AST_DRIVE_HOLD: assert property (
      $fell(o_sda_oe_n) |=> !o_sda_oe_n [*4])
      else $error("data drive too short");
   AST_RELEASED_AT_STOP: assert property (
      stop_age == 7'h00 |-> o_sda_oe_n)
      else $error("data pin held at stop");
   AST_BUSY_NEEDS_ADC: assert property (
      o_conv_busy |-> o_adc_enabled)
      else $error("busy while powered down");
   AST_ENABLE_AT_STOP: assert property (
      $changed(o_adc_enabled) |-> stop_age < 7'h10)
      else $error("converter state changed away from a stop");
endmodule

bind light_sensor_command_readout light_sensor_chk i_chk (
   .i_sys_clk(i_sys_clk),
   .i_rst_n(i_rst_n),
   .i_scl(i_scl),
   .i_sda(i_sda),
   .o_sda(o_sda),
   .o_sda_oe_n(o_sda_oe_n),
   .o_adc_enabled(o_adc_enabled),
   .o_conv_busy(o_conv_busy)
);
`default_nettype wire

// ==== testbench/i2c_master_model.sv ====
// Bus master model: drives the clock and open-drain data line.
// Assumes the bench resolves the line and calls one task at a time.
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
   input wire logic i_clk,
   input wire logic i_sda_line,
   output logic o_scl,
   output logic o_sda_drv,
   output logic o_res_valid,
   output logic [7:0] o_res
);
   initial begin
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
      o_res_valid = 1'b0;
      o_res = 8'h00;
   end
   // Result strobe stands one cycle
   always @(posedge i_clk) begin
      if (o_res_valid) begin
         o_res_valid <= 1'b0;
      end
   end
   // One bit: 4 cycles low, 4 high, line sampled before the fall
   task automatic bit_cyc(input logic v, output logic s);
      @(posedge i_clk);
      o_sda_drv <= v;
      repeat (3) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (4) @(posedge i_clk);
      s = i_sda_line;
      o_scl <= 1'b0;
   endtask
   task automatic start_cond;
      @(posedge i_clk);
      o_sda_drv <= 1'b1;
      o_scl <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sda_drv <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_scl <= 1'b0;
   endtask
   task automatic stop_cond;
      @(posedge i_clk);
      o_sda_drv <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sda_drv <= 1'b1;
      repeat (4) @(posedge i_clk);
   endtask
   task automatic tx(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
      bit_cyc(1'b1, s);
      o_res <= {7'h00, s};
      o_res_valid <= 1'b1;
   endtask
   task automatic rx(input logic nak);
      logic [7:0] b;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, s);
         b[i] = s;
      end
      bit_cyc(nak, s);
      o_res <= b;
      o_res_valid <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the light sensor command and readout block.
// Bus bytes are checked against a queue; pulse trains come from the bench.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic clk;
   logic rst_n = 1'b0;
   logic [2:0] addr_sel;
   logic [2:0] pulse_r = 3'h0;
   wire scl;
   wire sda_drv;
   wire sda_out;
   wire sda_oe_n;
   wire res_valid;
   wire [7:0] res;
   wire adc_en;
   wire busy;
   wire sda_line = sda_drv & (sda_oe_n | sda_out);
   logic [7:0] exp_q[$];
   logic [7:0] e;
   logic [7:0] t;
   logic [15:0] v = 16'h0000;
   logic [6:0] dev;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   int np;
   int no;
   light_sensor_command_readout i_dut (
      .i_sys_clk(clk),
      .i_rst_n(rst_n),
      .i_scl(scl),
      .i_sda(sda_line),
      .o_sda(sda_out),
      .o_sda_oe_n(sda_oe_n),
      .i_addr_select_bit0(addr_sel[0]),
      .i_addr_select_bit1(addr_sel[1]),
      .i_addr_select_bit2(addr_sel[2]),
      .i_osc_clk(pulse_r[2]),
      .i_primary_photocurrent(pulse_r[0]),
      .i_dark_photocurrent(pulse_r[1]),
      .o_adc_enabled(adc_en),
      .o_conv_busy(busy)
   );
   i2c_master_model i_master (
      .i_clk(clk),
      .i_sda_line(sda_line),
      .o_scl(scl),
      .o_sda_drv(sda_drv),
      .o_res_valid(res_valid),
      .o_res(res)
   );
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic end_of_test;
      if (exp_q.size() != 0) begin
         mismatches++;
         $display("wrong value pending notes expected 0 seen %0d", exp_q.size());
      end
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         end_of_test();
      end
   end
   // Each byte or acknowledge seen by the master takes the oldest note
   always @(posedge clk) begin
      if (res_valid) begin
         e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
         n_tests++;
         if (res !== e) begin
            mismatches++;
            $display("wrong value bus byte expected %h seen %h", e, res);
         end
      end
   end
   task automatic chk(input string nm, input logic x, input logic s);
      n_tests++;
      if (s !== x) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", nm, x, s);
      end
   endtask
   task automatic wr(input logic [6:0] a, input int n, input logic [7:0] d0,
                     input logic [7:0] d1, input logic [7:0] ak);
      repeat (n + 1) exp_q.push_back(ak);
      i_master.start_cond();
      i_master.tx({a, 1'b0});
      if (n > 0) i_master.tx(d0);
      if (n > 1) i_master.tx(d1);
      i_master.stop_cond();
      repeat (10) @(posedge clk);
   endtask
   // Reads n bytes, least significant first, master refusing the last
   task automatic rd(input int n, input logic [31:0] w);
      exp_q.push_back(8'h00);
      for (int i = 0; i < n; i++) exp_q.push_back(w[8 * i +: 8]);
      i_master.start_cond();
      i_master.tx({dev, 1'b1});
      for (int i = 1; i <= n; i++) i_master.rx(i == n);
      i_master.stop_cond();
      repeat (4) @(posedge clk);
   endtask
   task automatic pul(input int sel, input int n);
      repeat (n) begin
         @(posedge clk);
         pulse_r <= 3'h1 << sel;
         repeat (4) @(posedge clk);
         pulse_r <= 3'h0;
         repeat (3) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask
   initial begin
      void'($urandom(32'hBD929DD2));
      dev = {4'h8, 3'($urandom_range(7, 0))};
      @(posedge clk);
      addr_sel <= dev[2:0];
      repeat (19) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk("adc enabled", 1'b0, adc_en);
      wr(dev ^ 7'h01, 0, 8'h00, 8'h00, 8'h01);
      wr(dev ^ 7'h08, 0, 8'h00, 8'h00, 8'h01);
      for (int k = 0; k < 2; k++) begin
         wr(dev, 1, k ? 8'h34 : 8'h30, 8'h00, 8'h00);
         chk("adc enabled", 1'b1, adc_en);
         chk("busy", 1'b1, busy);
         np = $urandom_range(60, 1);
         no = $urandom_range(60, 1);
         pul(k, np);
         pul(1 - k, 3);
         pul(2, no);
         rd(2, 32'h0);
         wr(dev, k, 8'h34, 8'h00, 8'h00);
         rd(4, {16'(no), 16'(np)});
      end
      wr(dev, 1, 8'h38, 8'h00, 8'h00);
      np = $urandom_range(40, 1);
      no = np + $urandom_range(20, 1);
      pul(1, no);
      wr(dev, 0, 8'h00, 8'h00, 8'h00);
      pul(0, np);
      wr(dev, 0, 8'h00, 8'h00, 8'h00);
      v = 16'(np) - 16'(no);
      rd(2, {16'h0, v});
      t = 8'h80 | 8'($urandom_range(127, 0));
      if (t == 8'h8C) t = 8'h8D;
      wr(dev, 2, 8'h30, t, 8'h00);
      chk("busy", 1'b0, busy);
      rd(3, {8'h00, 8'hFF, t, t});
      for (int k = 0; k < 3; k++) begin
         wr(dev, 1, 8'(4 * k), 8'h00, 8'h00);
         chk("busy", 1'b1, busy);
         pul(k % 2, 4);
         rd(k == 2 ? 2 : 3, {8'h00, 8'hFF, v});
      end
      wr(dev, 1, 8'h8C, 8'h00, 8'h00);
      chk("adc enabled", 1'b0, adc_en);
      chk("busy", 1'b0, busy);
      rd(2, {16'h0, v});
      wr(dev, 1, 8'h0C, 8'h00, 8'h00);
      chk("adc enabled", 1'b1, adc_en);
      chk("busy", 1'b0, busy);
      wr(dev, 1, 8'h30, 8'h00, 8'h00);
      wr(dev, 1, 8'h8C, 8'h00, 8'h00);
      chk("adc enabled", 1'b0, adc_en);
      rd(3, {8'h00, 8'hFF, v});
      end_of_test();
   end
endmodule
`default_nettype wire
